// ---- core/srtm_map.svh ----
`ifndef SRTM_MAP_SVH
`define SRTM_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define SRTM_A_PAGE      12'h300
`define SRTM_A_LANE_EN   12'h315
`define SRTM_A_PCTL      12'h316
`define SRTM_A_LIMIT0    12'h317
`define SRTM_A_LIMIT1    12'h318
`define SRTM_A_LIMIT2    12'h319
`define SRTM_A_PCNT0     12'h31a
`define SRTM_A_PCNT1     12'h31b
`define SRTM_A_PCNT2     12'h31c
`define SRTM_A_PASS      12'h31d
`define SRTM_A_TCTL      12'h32c
`define SRTM_A_TREF_LO   12'h32d
`define SRTM_A_TREF_HI   12'h32e
`define SRTM_A_TRES      12'h32f
`define SRTM_A_ESEL      12'h46b
`define SRTM_A_EDISP     12'h46d
`define SRTM_A_ETABLE    12'h46e
`define SRTM_A_ECTRL     12'h46f
`define SRTM_A_CGS       12'h470
`define SRTM_A_ALIGN     12'h473
`define SRTM_A_TOPT      12'h477
`define SRTM_A_ETHR      12'h47c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SRTM_PAGE_LINK   2
`define SRTM_PCTL_CLR    0
`define SRTM_PCTL_RUN    1
`define SRTM_PCTL_PAT    3:2
`define SRTM_PCTL_PICK   6:4
`define SRTM_TCTL_EN     0
`define SRTM_TCTL_CLR    1
`define SRTM_TCTL_CONV   3:2
`define SRTM_TCTL_IDX    5:4
`define SRTM_ESEL_LANE   6:4
`define SRTM_ESEL_TYPE   1:0
`define SRTM_ECMD_IRQ    7
`define SRTM_ECMD_STOP   6
`define SRTM_ECMD_CLR    5
`define SRTM_ECMD_LANE   2:0
`define SRTM_TOPT_ILAS   7

// ----------------------------------------------------------------
// patterns, counts, reset values
// ----------------------------------------------------------------
`define SRTM_PAT_P7      2'h0
`define SRTM_PAT_P15     2'h1
`define SRTM_PAT_P31     2'h2
`define SRTM_P7_TAP_A    6
`define SRTM_P7_TAP_B    5
`define SRTM_P15_TAP_A   14
`define SRTM_P15_TAP_B   13
`define SRTM_P31_TAP_A   30
`define SRTM_P31_TAP_B   27
`define SRTM_PRIME_BITS  5'h1f
`define SRTM_PCNT_MAX    24'hffffff
`define SRTM_CGS_COMMAS  3'h4
`define SRTM_LINK1_OFS   3'h4
`define SRTM_REG_RESET   8'h00

`endif

// ---- core/srtm_pkg.sv ----
package srtm_pkg;

  // prbs test phase
  typedef enum logic [2:0] {
    SRTM_PH_IDLE = 3'b001,
    SRTM_PH_RUN  = 3'b010,
    SRTM_PH_HOLD = 3'b100
  } srtm_phase_e;

  // per-lane character events from the deframer
  typedef struct packed {
    logic [7:0] valid;
    logic [7:0] dispar_err;
    logic [7:0] table_err;
    logic [7:0] ctrl_err;
    logic [7:0] comma;
    logic [7:0] ilas_ok;
  } srtm_lane_s;

  // one received transport sample
  typedef struct packed {
    logic        valid;
    logic [1:0]  conv;
    logic [1:0]  idx;
    logic [15:0] data;
  } srtm_sample_s;

  // software-visible storage
  typedef struct packed {
    logic [7:0]  page;
    logic [7:0]  lane_en;
    logic [7:0]  pctl;
    logic [23:0] limit;
    logic [7:0]  tctl;
    logic [15:0] tref;
    logic [7:0]  esel;
    logic [7:0]  topt;
    logic [7:0]  ethr;
  } srtm_regs_s;

  // whole block state
  typedef struct packed {
    srtm_regs_s          r;
    srtm_phase_e         phase;
    logic                run_seen;
    logic [7:0][30:0]    hist;
    logic [7:0][4:0]     prime;
    logic [7:0][23:0]    pcnt;
    logic                tclr_seen;
    logic                tarm;
    logic                tfail;
    logic [7:0][2:0]     commas;
    logic [7:0]          align;
    logic                sync_n;
    logic [2:0][7:0][7:0] ecnt;
    logic [2:0][7:0]     estop;
    logic [2:0][7:0]     ehit;
    logic [7:0]          rdata;
  } srtm_state_s;

endpackage : srtm_pkg

// ---- core/srtm_monitor.sv ----
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`include "srtm_map.svh"

module srtm_monitor
  import srtm_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  // register port
  input  wire logic [11:0]  reg_addr_i,
  input  wire logic [7:0]   reg_wdata_i,
  input  wire logic         reg_write_i,
  input  wire logic         reg_read_i,
  output logic      [7:0]   reg_rdata_o,
  // physical lanes, one bit per lane per valid cycle
  input  wire logic [7:0]   prbs_bit_i,
  input  wire logic         prbs_valid_i,
  // deframer side
  input  wire srtm_lane_s   lane_i,
  input  wire logic [7:0]   lanes_active_i,
  input  wire srtm_sample_s sample_i,
  // link side
  output logic              sync_request_out_n_o,
  output logic              ilas_repeat_test_o
);

  srtm_state_s st;
  srtm_state_s next_st;
  logic [7:0]  pass_vec;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic srtm_expect(input logic [30:0] h, input logic [1:0] pat);
    logic e;
    e = 1'b0;
    case (pat)
      `SRTM_PAT_P15: e = h[`SRTM_P15_TAP_A] ^ h[`SRTM_P15_TAP_B];
      `SRTM_PAT_P31: e = h[`SRTM_P31_TAP_A] ^ h[`SRTM_P31_TAP_B];
      default:       e = h[`SRTM_P7_TAP_A] ^ h[`SRTM_P7_TAP_B];
    endcase
    return e;
  endfunction : srtm_expect

  function automatic logic [2:0] srtm_lane_map(input logic [2:0] x, input logic link1);
    return x + (link1 ? `SRTM_LINK1_OFS : 3'h0);
  endfunction : srtm_lane_map

  // ----------------------------------------------------------------
  // pass flags
  // ----------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pass_vec[i] = (st.pcnt[i] <= st.r.limit);
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0]  ev;
    logic [2:0]  ln;
    logic [2:0]  pick;
    logic        link1;
    next_st = st;
    ev      = 8'h00;
    ln      = 3'h0;
    link1   = st.r.page[`SRTM_PAGE_LINK];
    pick    = st.r.pctl[`SRTM_PCTL_PICK];
    next_st.rdata = `SRTM_REG_RESET;

    // register writes
    if (reg_write_i) begin
      if (reg_addr_i == `SRTM_A_PAGE) begin
        next_st.r.page = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_LANE_EN) begin
        next_st.r.lane_en = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_PCTL) begin
        next_st.r.pctl = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_LIMIT0) begin
        next_st.r.limit[7:0] = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_LIMIT1) begin
        next_st.r.limit[15:8] = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_LIMIT2) begin
        next_st.r.limit[23:16] = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_TCTL) begin
        next_st.r.tctl = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_TREF_LO) begin
        next_st.r.tref[7:0] = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_TREF_HI) begin
        next_st.r.tref[15:8] = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_ESEL) begin
        next_st.r.esel = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_TOPT) begin
        next_st.r.topt = reg_wdata_i;
      end else if (reg_addr_i == `SRTM_A_ETHR) begin
        next_st.r.ethr = reg_wdata_i;
      end else if (reg_addr_i >= `SRTM_A_EDISP && reg_addr_i <= `SRTM_A_ECTRL) begin
        ln = srtm_lane_map(reg_wdata_i[`SRTM_ECMD_LANE], link1);
        for (int t = 0; t < 3; t++) begin
          if (reg_addr_i == `SRTM_A_EDISP + 12'(t)) begin
            if (reg_wdata_i[`SRTM_ECMD_IRQ]) next_st.ehit[t][ln] = 1'b0;
            next_st.estop[t][ln] = reg_wdata_i[`SRTM_ECMD_STOP];
            if (reg_wdata_i[`SRTM_ECMD_CLR]) next_st.ecnt[t][ln] = 8'h00;
          end
        end
      end
    end

    // test phase, started by a rising run bit
    next_st.run_seen = st.r.pctl[`SRTM_PCTL_RUN];
    case (st.phase)
      SRTM_PH_IDLE,
      SRTM_PH_HOLD: begin
        if (st.r.pctl[`SRTM_PCTL_RUN] && !st.run_seen) next_st.phase = SRTM_PH_RUN;
      end
      SRTM_PH_RUN: begin
        if (!st.r.pctl[`SRTM_PCTL_RUN]) next_st.phase = SRTM_PH_HOLD;
      end
      default: next_st.phase = SRTM_PH_IDLE;
    endcase

    // self-synchronising check, independent of the link
    for (int i = 0; i < 8; i++) begin
      if (prbs_valid_i && st.r.lane_en[i] && st.phase == SRTM_PH_RUN) begin
        next_st.hist[i] = {st.hist[i][29:0], prbs_bit_i[i]};
        if (st.prime[i] != `SRTM_PRIME_BITS) begin
          next_st.prime[i] = st.prime[i] + 5'h01;
        // expected bit from the picked polynomial
        end else if (prbs_bit_i[i] != srtm_expect(st.hist[i], st.r.pctl[`SRTM_PCTL_PAT])) begin
          if (st.pcnt[i] != `SRTM_PCNT_MAX) next_st.pcnt[i] = st.pcnt[i] + 24'h000001;
        end
      end
      // clear level reinitialises; otherwise results hold
      if (st.r.pctl[`SRTM_PCTL_CLR]) begin
        next_st.hist[i]  = 31'h0;
        next_st.prime[i] = 5'h00;
        next_st.pcnt[i]  = 24'h000000;
      end
    end

    // compare armed by the falling clear while enabled
    next_st.tclr_seen = st.r.tctl[`SRTM_TCTL_CLR];
    if (!st.r.tctl[`SRTM_TCTL_EN] || st.r.tctl[`SRTM_TCTL_CLR]) begin
      next_st.tarm  = 1'b0;
      next_st.tfail = 1'b0;
    end else if (st.tclr_seen) begin
      next_st.tarm = 1'b1;
    end
    if (st.tarm && sample_i.valid && sample_i.conv == st.r.tctl[`SRTM_TCTL_CONV]
        && sample_i.idx == st.r.tctl[`SRTM_TCTL_IDX] && sample_i.data != st.r.tref) begin
      next_st.tfail = 1'b1;
    end

    for (int i = 0; i < 8; i++) begin
      if (!lanes_active_i[i]) begin
        next_st.commas[i] = 3'h0;
      end else if (lane_i.valid[i] && lane_i.comma[i] && st.commas[i] != `SRTM_CGS_COMMAS) begin
        next_st.commas[i] = st.commas[i] + 3'h1;
      end
    end
    next_st.sync_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (lanes_active_i[i] && st.commas[i] != `SRTM_CGS_COMMAS) next_st.sync_n = 1'b0;
    end
    if (lanes_active_i == 8'h00) next_st.sync_n = 1'b0;
    next_st.align = lane_i.ilas_ok & lanes_active_i;

    // error counters; event after command, so a new event wins
    for (int t = 0; t < 3; t++) begin
      // disparity input counts each valid bad-disparity char while the lane is not stopped and below the threshold
      ev = (t == 0) ? lane_i.dispar_err : (t == 1) ? lane_i.table_err : lane_i.ctrl_err;
      for (int l = 0; l < 8; l++) begin
        // count stops at the shared threshold
        if (lane_i.valid[l] && ev[l] && !next_st.estop[t][l] && next_st.ecnt[t][l] < st.r.ethr) begin
          next_st.ecnt[t][l] = next_st.ecnt[t][l] + 8'h01;
        end
        if (next_st.ecnt[t][l] >= st.r.ethr && lane_i.valid[l] && ev[l]) begin
          next_st.ehit[t][l] = 1'b1;
        end
      end
    end

    // read port
    if (reg_read_i) begin
      if (reg_addr_i == `SRTM_A_PAGE) begin
        next_st.rdata = st.r.page;
      end else if (reg_addr_i == `SRTM_A_LANE_EN) begin
        next_st.rdata = st.r.lane_en;
      end else if (reg_addr_i == `SRTM_A_PCTL) begin
        next_st.rdata = st.r.pctl;
      end else if (reg_addr_i == `SRTM_A_LIMIT0) begin
        next_st.rdata = st.r.limit[7:0];
      end else if (reg_addr_i == `SRTM_A_LIMIT1) begin
        next_st.rdata = st.r.limit[15:8];
      end else if (reg_addr_i == `SRTM_A_LIMIT2) begin
        next_st.rdata = st.r.limit[23:16];
      end else if (reg_addr_i == `SRTM_A_PCNT0) begin
        next_st.rdata = st.pcnt[pick][7:0];
      end else if (reg_addr_i == `SRTM_A_PCNT1) begin
        next_st.rdata = st.pcnt[pick][15:8];
      end else if (reg_addr_i == `SRTM_A_PCNT2) begin
        next_st.rdata = st.pcnt[pick][23:16];
      end else if (reg_addr_i == `SRTM_A_PASS) begin
        next_st.rdata = pass_vec;
      end else if (reg_addr_i == `SRTM_A_TCTL) begin
        next_st.rdata = st.r.tctl;
      end else if (reg_addr_i == `SRTM_A_TREF_LO) begin
        next_st.rdata = st.r.tref[7:0];
      end else if (reg_addr_i == `SRTM_A_TREF_HI) begin
        next_st.rdata = st.r.tref[15:8];
      end else if (reg_addr_i == `SRTM_A_TRES) begin
        next_st.rdata = {7'h00, st.tfail};
      end else if (reg_addr_i == `SRTM_A_ESEL) begin
        // selected count of the paged lane
        ln = srtm_lane_map(st.r.esel[`SRTM_ESEL_LANE], link1);
        if (st.r.esel[`SRTM_ESEL_TYPE] != 2'h3) begin
          next_st.rdata = st.ecnt[st.r.esel[`SRTM_ESEL_TYPE]][ln];
        end
      end else if (reg_addr_i >= `SRTM_A_EDISP && reg_addr_i <= `SRTM_A_ECTRL) begin
        for (int x = 0; x < 8; x++) begin
          ln = srtm_lane_map(3'(x), link1);
          next_st.rdata[x] = st.ehit[reg_addr_i[1:0] - 2'h1][ln];
        end
      end else if (reg_addr_i == `SRTM_A_CGS) begin
        for (int x = 0; x < 8; x++) begin
          ln = srtm_lane_map(3'(x), link1);
          next_st.rdata[x] = (st.commas[ln] == `SRTM_CGS_COMMAS);
        end
      end else if (reg_addr_i == `SRTM_A_ALIGN) begin
        for (int x = 0; x < 8; x++) begin
          ln = srtm_lane_map(3'(x), link1);
          next_st.rdata[x] = st.align[ln];
        end
      end else if (reg_addr_i == `SRTM_A_TOPT) begin
        next_st.rdata = st.r.topt;
      end else if (reg_addr_i == `SRTM_A_ETHR) begin
        next_st.rdata = st.r.ethr;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      st       <= '0;
      st.phase <= SRTM_PH_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o          = st.rdata;
  assign sync_request_out_n_o = st.sync_n;
  // repeated alignment request toward the link
  assign ilas_repeat_test_o   = st.r.topt[`SRTM_TOPT_ILAS];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_pattern_default: assert property (@(posedge core_clk_i)
    $fell(reset_i) |-> st.r.pctl[`SRTM_PCTL_PAT] == `SRTM_PAT_P7)
    else $error("pattern pick not prbs7 after reset");

  a_clear_counts: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st.r.pctl[`SRTM_PCTL_CLR] |=> st.pcnt == '0 && st.prime == '0)
    else $error("clear did not reinitialise checkers");

  a_start_edge: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (st.phase == SRTM_PH_RUN && $past(st.phase) != SRTM_PH_RUN)
    |-> $past(st.r.pctl[`SRTM_PCTL_RUN] && !st.run_seen))
    else $error("test started without rising run bit");

  a_pass_read: assert property (@(posedge core_clk_i) disable iff (reset_i)
    reg_read_i && reg_addr_i == `SRTM_A_PASS |=> reg_rdata_o == $past(pass_vec))
    else $error("pass flags read wrong");

  a_count_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st.phase == SRTM_PH_HOLD && !st.r.pctl[`SRTM_PCTL_CLR] && !$rose(st.r.pctl[`SRTM_PCTL_RUN])
    |=> st.pcnt == $past(st.pcnt))
    else $error("prbs counts moved while stopped");

  a_sample_fail: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st.tarm && sample_i.valid && sample_i.conv == st.r.tctl[`SRTM_TCTL_CONV]
    && sample_i.idx == st.r.tctl[`SRTM_TCTL_IDX] && sample_i.data != st.r.tref
    && st.r.tctl[`SRTM_TCTL_EN] && !st.r.tctl[`SRTM_TCTL_CLR] |=> st.tfail)
    else $error("sample mismatch not flagged");

  a_sync_release: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $rose(sync_request_out_n_o) |-> $past(lanes_active_i) != 8'h00)
    else $error("sync released with no active lane");

  a_thresh_stop: assert property (@(posedge core_clk_i) disable iff (reset_i)
    st.ecnt[0][5] > $past(st.ecnt[0][5]) |-> $past(st.ecnt[0][5]) < $past(st.r.ethr))
    else $error("error count passed threshold");

  a_count_clear: assert property (@(posedge core_clk_i) disable iff (reset_i)
    reg_write_i && reg_addr_i == `SRTM_A_EDISP && reg_wdata_i == 8'ha1
    && st.r.page[`SRTM_PAGE_LINK] && !lane_i.dispar_err[5] |=> st.ecnt[0][5] == 8'h00)
    else $error("count clear command ignored");

endmodule : srtm_monitor

// ---- dv/srtm_tx_model.sv ----
`timescale 1ns/1ps

module srtm_tx_model
  import srtm_pkg::*;
(
  // clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  // bench controls
  input  wire logic [1:0]   pat_i,
  input  wire logic [7:0]   flip_i,
  input  wire logic         commas_i,
  input  wire srtm_lane_s   inj_i,
  // receiver feedback
  input  wire logic         sync_n_i,
  input  wire logic         ilas_mode_i,
  // toward the receiver
  output logic [7:0]        prbs_bit_o,
  output logic              prbs_valid_o,
  output srtm_lane_s        lane_o,
  output srtm_sample_s      sample_o
);
  logic [30:0] lfsr;
  logic        fb;
  logic [3:0]  spos;

  always_comb begin
    case (pat_i)
      2'h1: fb = lfsr[14] ^ lfsr[13];
      2'h2: fb = lfsr[30] ^ lfsr[27];
      default: fb = lfsr[6] ^ lfsr[5];
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      lfsr <= 31'h1;
      spos <= 4'h0;
      prbs_bit_o <= 8'h00;
      prbs_valid_o <= 1'b0;
      lane_o <= '0;
      sample_o <= '0;
    end else begin
      lfsr <= {lfsr[29:0], fb};
      prbs_bit_o <= {8{fb}} ^ flip_i;
      prbs_valid_o <= 1'b1;
      spos <= spos + 4'h1;
      sample_o <= '{valid: 1'b1, conv: spos[3:2], idx: spos[1:0], data: {12'h5a3, spos}};
      lane_o <= '{valid: 8'hff, dispar_err: inj_i.dispar_err, table_err: inj_i.table_err,
                  ctrl_err: inj_i.ctrl_err, comma: {8{commas_i}},
                  ilas_ok: {8{sync_n_i & ilas_mode_i}}};
    end
  end
endmodule : srtm_tx_model

// ---- dv/serdes_rx_test_and_error_monitor_test.sv ----
`timescale 1ns/1ps
`include "srtm_map.svh"

module serdes_rx_test_and_error_monitor_test
  import srtm_pkg::*;
;
  logic         core_clk;
  logic         reset;
  logic [11:0]  addr;
  logic [7:0]   wdata;
  logic         we;
  logic         re;
  logic [7:0]   rdata;
  logic [7:0]   prbs_bit;
  logic         prbs_valid;
  srtm_lane_s   lane;
  srtm_lane_s   inj;
  srtm_sample_s sample;
  logic [7:0]   lanes_active;
  logic         sync_n;
  logic         ilas_rep;
  logic [1:0]   pat;
  logic [7:0]   flip;
  logic         commas;
  int           miscompares;
  int           check_count;
  int           cycles;

  srtm_monitor srtm_monitor_i (
    .core_clk_i(core_clk), .reset_i(reset), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(we), .reg_read_i(re), .reg_rdata_o(rdata), .prbs_bit_i(prbs_bit),
    .prbs_valid_i(prbs_valid), .lane_i(lane), .lanes_active_i(lanes_active),
    .sample_i(sample), .sync_request_out_n_o(sync_n), .ilas_repeat_test_o(ilas_rep));

  srtm_tx_model srtm_tx_model_i (
    .core_clk_i(core_clk), .reset_i(reset), .pat_i(pat), .flip_i(flip),
    .commas_i(commas), .inj_i(inj), .sync_n_i(sync_n), .ilas_mode_i(ilas_rep),
    .prbs_bit_o(prbs_bit), .prbs_valid_o(prbs_valid), .lane_o(lane), .sample_o(sample));

  // ----------------------------------------------------------------
  // register access and checking
  // ----------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge core_clk);
    we <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    addr <= a;
    re <= 1'b1;
    @(posedge core_clk);
    re <= 1'b0;
    @(negedge core_clk);
    chk(rdata, exp);
  endtask : rd

  task pulse_flip(input logic [7:0] m, input int gap);
    repeat (gap) @(posedge core_clk);
    flip <= m;
    @(posedge core_clk);
    flip <= 8'h00;
    repeat (gap) @(posedge core_clk);
  endtask : pulse_flip

  task inj_err(input logic [2:0] k, input int n);
    repeat (n) begin
      @(posedge core_clk);
      inj.dispar_err <= {2'h0, k[0], 5'h0};
      inj.table_err <= {2'h0, k[1], 5'h0};
      inj.ctrl_err <= {2'h0, k[2], 5'h0};
      @(posedge core_clk);
      inj <= '0;
    end
  endtask : inj_err

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task check_reset;
    rd(`SRTM_A_ETHR, 8'h00);
    rd(`SRTM_A_PCTL, 8'h00);
    rd(`SRTM_A_TOPT, 8'h00);
    chk({7'h0, sync_n}, 8'h00);
    wr(`SRTM_A_ETHR, 8'h5c);
    rd(`SRTM_A_ETHR, 8'h5c);
    wr(12'h123, 8'hff);
    rd(12'h123, 8'h00);
    wr(`SRTM_A_CGS, 8'hff);
    rd(`SRTM_A_CGS, 8'h00);
  endtask : check_reset

  task prbs_test;
    for (int p = 0; p < 3; p++) begin
      @(posedge core_clk);
      pat <= p[1:0];
      wr(`SRTM_A_LANE_EN, 8'h0f);
      wr(`SRTM_A_LIMIT0, (p == 2) ? 8'h03 : 8'h00);
      wr(`SRTM_A_PCTL, {4'h0, p[1:0], 2'h1});
      wr(`SRTM_A_PCTL, {4'h0, p[1:0], 2'h0});
      wr(`SRTM_A_PCTL, {4'h0, p[1:0], 2'h2});
      pulse_flip(8'h24, 60);
      wr(`SRTM_A_PCTL, {4'h0, p[1:0], 2'h0});
      rd(`SRTM_A_PASS, (p == 2) ? 8'hff : 8'hfb);
      wr(`SRTM_A_PCTL, {4'h2, p[1:0], 2'h0});
      rd(`SRTM_A_PCNT0, 8'h03);
      rd(`SRTM_A_PCNT1, 8'h00);
      rd(`SRTM_A_PCNT2, 8'h00);
      pulse_flip(8'h24, 40);
      rd(`SRTM_A_PCNT0, 8'h03);
      wr(`SRTM_A_PCTL, {4'h2, p[1:0], 2'h1});
      wr(`SRTM_A_PCTL, {4'h2, p[1:0], 2'h0});
      rd(`SRTM_A_PCNT0, 8'h00);
    end
  endtask : prbs_test

  task sample_test;
    logic [1:0] ix;
    for (int c = 0; c < 4; c++) begin
      ix = 2'h3 - c[1:0];
      wr(`SRTM_A_TREF_LO, {4'h3, c[1:0], ix});
      wr(`SRTM_A_TREF_HI, (c == 3) ? 8'h00 : 8'h5a);
      wr(`SRTM_A_TCTL, {2'h0, ix, c[1:0], 2'h1});
      wr(`SRTM_A_TCTL, {2'h0, ix, c[1:0], 2'h3});
      wr(`SRTM_A_TCTL, {2'h0, ix, c[1:0], 2'h1});
      repeat (20) @(posedge core_clk);
      rd(`SRTM_A_TRES, (c == 3) ? 8'h01 : 8'h00);
    end
  endtask : sample_test

  task cgs_test;
    wr(`SRTM_A_TOPT, 8'h80);
    @(negedge core_clk);
    chk({7'h0, ilas_rep}, 8'h01);
    @(posedge core_clk);
    commas <= 1'b1;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    chk({7'h0, sync_n}, 8'h01);
    rd(`SRTM_A_CGS, 8'hff);
    rd(`SRTM_A_ALIGN, 8'hff);
  endtask : cgs_test

  task error_test;
    wr(`SRTM_A_ETHR, 8'h02);
    wr(`SRTM_A_PAGE, 8'h04);
    inj_err(3'h3, 3);
    wr(`SRTM_A_ESEL, 8'h10);
    rd(`SRTM_A_ESEL, 8'h02);
    wr(`SRTM_A_ESEL, 8'h11);
    rd(`SRTM_A_ESEL, 8'h02);
    rd(`SRTM_A_EDISP, 8'h02);
    rd(`SRTM_A_ETABLE, 8'h02);
    wr(`SRTM_A_EDISP, 8'ha1);
    rd(`SRTM_A_EDISP, 8'h00);
    wr(`SRTM_A_ESEL, 8'h10);
    rd(`SRTM_A_ESEL, 8'h00);
    wr(`SRTM_A_ECTRL, 8'h41);
    inj_err(3'h4, 1);
    wr(`SRTM_A_ESEL, 8'h12);
    rd(`SRTM_A_ESEL, 8'h00);
    wr(`SRTM_A_ECTRL, 8'h01);
    inj_err(3'h4, 1);
    rd(`SRTM_A_ESEL, 8'h01);
    wr(`SRTM_A_PAGE, 8'h00);
    wr(`SRTM_A_ESEL, 8'h52);
    rd(`SRTM_A_ESEL, 8'h01);
  endtask : error_test

  // ----------------------------------------------------------------
  // verdict, clock, sequence
  // ----------------------------------------------------------------
  task give_verdict;
    $display("checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  always #20 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    addr = 12'h000;
    wdata = 8'h00;
    we = 1'b0;
    re = 1'b0;
    inj = '0;
    lanes_active = 8'hff;
    pat = 2'h0;
    flip = 8'h00;
    commas = 1'b0;
    miscompares = 0;
    check_count = 0;
    cycles = 0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    check_reset();
    prbs_test();
    sample_test();
    cgs_test();
    error_test();
    give_verdict();
  end
endmodule : serdes_rx_test_and_error_monitor_test
